// File: rtl/mcr_regs.sv
// How it works
// RULE_01 - status word bits 31-16 show measured bus current, lsb 1/256 ampere.
// RULE_02 - status word bits 15-0 show input power, lsb 1/64 watt.
// RULE_03 - writing one to store bit copies shadow settings into nonvolatile memory.
// RULE_04 - writing one to load bit copies nonvolatile memory into shadow settings.
// RULE_05 - writing one to fault clear bit clears all driver and controller faults.
// RULE_06 - writing one to retry clear bit resets the lock fault retry counters.
// RULE_07 - an 8-bit key in bits 27-20 must accompany every store request.
// RULE_08 - host sets watchdog kick bit periodically; device clears it by itself.
// RULE_09 - host leaves unlisted offsets alone; they are reserved.
// RULE_10 - write-only command word sits at E6h and resets to zero.
// RULE_11 - speed word at E8h resets to zero; bits 14-0 read zero.
// RULE_12 - setpoint in bits 30-16; percent equals value over 32767 times 100.
// RULE_13 - source bit zero picks pin speed input, one picks digital setpoint.
// RULE_14 - store, load and both clears are one-shot pulses, one per write.
// RULE_15 - a store with the wrong key is dropped; memory stays unchanged.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
module mcr_regs
    import mcr_pkg::*;
#(
    parameter logic [7:0] NVM_KEY = MCR_NVM_KEY_DEF
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // avalon-mm slave
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // measurements and speed pin
    input wire logic [15:0] bus_current_reading_i,
    input wire logic [15:0] input_power_reading_i,
    input wire logic [14:0] speed_pin_cmd_i,
    input wire logic wd_seen_i,
    // commands to the motor control core
    output logic nvm_store_cmd_o,
    output logic nvm_load_cmd_o,
    output logic fault_clear_cmd_o,
    output logic retry_counter_clear_cmd_o,
    output logic key_reject_o,
    output logic host_watchdog_kick_o,
    // speed command
    output logic [14:0] speed_setpoint_o,
    output logic speed_source_select_o,
    output logic [14:0] speed_cmd_o
);

    mcr_bus_t state_r, state_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] speed_r, speed_nxt;
    mcr_meas_t meas_r, meas_nxt;
    logic kick_r, kick_nxt;
    logic [14:0] scmd_r, scmd_nxt;
    logic req, accept, wr_done, algo_wr;
    logic [9:0] idx;
    logic [31:0] wmask, wdata_m;
    mcr_cmd_t cmd;

    // bus side: one wait cycle, then the answer
    always_comb begin
        req = avs_read_i | avs_write_i;
        idx = avs_address_i[11:2];
        accept = req && (state_r == MCR_BUS_IDLE);
        wr_done = avs_write_i && (state_r == MCR_BUS_ACK);
        wmask = mcr_be_mask(avs_byteenable_i);
        wdata_m = avs_writedata_i & wmask;
        algo_wr = wr_done && (idx == MCR_IDX_ALGO_CMD); // RULE_10
        state_nxt = state_r;
        case (state_r)
            MCR_BUS_IDLE: begin
                if (req) begin
                    state_nxt = MCR_BUS_ACK;
                end
            end
            MCR_BUS_ACK: begin
                state_nxt = MCR_BUS_IDLE;
            end
            default: begin
                state_nxt = MCR_BUS_IDLE;
            end
        endcase
        rdata_nxt = rdata_r;
        if (accept && avs_read_i) begin
            case (idx)
                MCR_IDX_STATUS: begin
                    rdata_nxt = {meas_r.current, meas_r.power}; // RULE_01 RULE_02
                end
                MCR_IDX_SPEED_CMD: begin
                    rdata_nxt = speed_r & MCR_SPEED_WR_MASK; // RULE_11
                end
                // command word is write-only; unmapped reads give zero
                default: begin
                    rdata_nxt = MCR_RDATA_RST; // RULE_10
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= MCR_BUS_IDLE;
            rdata_r <= MCR_RDATA_RST;
        end else begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest_o = req && (state_r != MCR_BUS_ACK);
    assign avs_readdata_o = rdata_r;

    // speed word, measurements, watchdog kick
    always_comb begin
        speed_nxt = speed_r;
        if (wr_done && (idx == MCR_IDX_SPEED_CMD)) begin
            speed_nxt = ((speed_r & ~wmask) | wdata_m) & MCR_SPEED_WR_MASK; // RULE_11
        end
        meas_nxt.current = bus_current_reading_i; // RULE_01
        meas_nxt.power = input_power_reading_i; // RULE_02
        // core clears the kick; a new kick in the same cycle wins
        kick_nxt = kick_r && !wd_seen_i; // RULE_08
        if (cmd.kick) begin
            kick_nxt = 1'b1; // RULE_08
        end
        // registered mux keeps the speed path glitch free
        if (speed_r[MCR_SRC_BIT]) begin // RULE_13
            scmd_nxt = speed_r[MCR_SETPT_HI:MCR_SETPT_LO]; // RULE_12
        end else begin
            scmd_nxt = speed_pin_cmd_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            speed_r <= MCR_SPEED_RST;
            meas_r <= '0;
            kick_r <= 1'b0;
            scmd_r <= '0;
        end else begin
            speed_r <= speed_nxt;
            meas_r <= meas_nxt;
            kick_r <= kick_nxt;
            scmd_r <= scmd_nxt;
        end
    end

    mcr_cmd_decode #(
        .NVM_KEY(NVM_KEY)
    ) u_decode (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .wr_i(algo_wr),
        .data_i(wdata_m),
        .cmd_o(cmd),
        .key_reject_o(key_reject_o)
    );

    assign nvm_store_cmd_o = cmd.store;
    assign nvm_load_cmd_o = cmd.load;
    assign fault_clear_cmd_o = cmd.fault_clear;
    assign retry_counter_clear_cmd_o = cmd.retry_clear;
    assign host_watchdog_kick_o = kick_r;
    assign speed_setpoint_o = speed_r[MCR_SETPT_HI:MCR_SETPT_LO];
    assign speed_source_select_o = speed_r[MCR_SRC_BIT];
    assign speed_cmd_o = scmd_r;

    // checks

    property p_status_cur;
        @(posedge mclk_i) disable iff (!rstn_i)
        (accept && avs_read_i && (idx == MCR_IDX_STATUS))
            |=> (avs_readdata_o[MCR_CUR_HI:MCR_CUR_LO] == $past(meas_r.current));
    endproperty
    a_status_cur: assert property (p_status_cur) // RULE_01
        else $error("status current half wrong");

    property p_status_pwr;
        @(posedge mclk_i) disable iff (!rstn_i)
        (accept && avs_read_i && (idx == MCR_IDX_STATUS))
            ##1 !avs_waitrequest_o
            |-> (avs_readdata_o[MCR_PWR_HI:MCR_PWR_LO] == $past(input_power_reading_i, 2));
    endproperty
    a_status_pwr: assert property (p_status_pwr) // RULE_02
        else $error("status power half wrong");

    property p_store;
        @(posedge mclk_i) disable iff (!rstn_i)
        (algo_wr && wdata_m[MCR_STORE_BIT] && (wdata_m[MCR_KEY_HI:MCR_KEY_LO] == NVM_KEY))
            |=> nvm_store_cmd_o && !key_reject_o;
    endproperty
    a_store: assert property (p_store) // RULE_03
        else $error("keyed store did not pulse");

    property p_load;
        @(posedge mclk_i) disable iff (!rstn_i)
        algo_wr |=> (nvm_load_cmd_o == $past(wdata_m[MCR_LOAD_BIT]));
    endproperty
    a_load: assert property (p_load) // RULE_04
        else $error("load pulse mismatch");

    property p_fclr;
        @(posedge mclk_i) disable iff (!rstn_i)
        fault_clear_cmd_o |-> $past(algo_wr) && $past(wdata_m[MCR_FCLR_BIT]);
    endproperty
    a_fclr: assert property (p_fclr) // RULE_05
        else $error("fault clear without a write");

    property p_rclr;
        @(posedge mclk_i) disable iff (!rstn_i)
        (algo_wr && wdata_m[MCR_RCLR_BIT]) |=> retry_counter_clear_cmd_o ##1 1'b1;
    endproperty
    a_rclr: assert property (p_rclr) // RULE_06
        else $error("retry clear did not pulse");

    property p_badkey;
        @(posedge mclk_i) disable iff (!rstn_i)
        (algo_wr && wdata_m[MCR_STORE_BIT] && (wdata_m[MCR_KEY_HI:MCR_KEY_LO] != NVM_KEY))
            |=> !nvm_store_cmd_o && key_reject_o;
    endproperty
    a_badkey: assert property (p_badkey) // RULE_15 RULE_07
        else $error("store with bad key went through");

    property p_kick_set;
        @(posedge mclk_i) disable iff (!rstn_i)
        (algo_wr && wdata_m[MCR_KICK_BIT]) |-> ##2 host_watchdog_kick_o;
    endproperty
    a_kick_set: assert property (p_kick_set) // RULE_08
        else $error("watchdog kick not set");

    property p_kick_clr;
        @(posedge mclk_i) disable iff (!rstn_i)
        (host_watchdog_kick_o && wd_seen_i && !cmd.kick) |=> !host_watchdog_kick_o;
    endproperty
    a_kick_clr: assert property (p_kick_clr) // RULE_08
        else $error("watchdog kick not cleared");

    property p_pulse_once;
        @(posedge mclk_i) disable iff (!rstn_i)
        (nvm_store_cmd_o || nvm_load_cmd_o) |=> !(nvm_store_cmd_o || nvm_load_cmd_o);
    endproperty
    a_pulse_once: assert property (p_pulse_once) // RULE_14
        else $error("command held longer than one cycle");

    property p_algo_rd;
        @(posedge mclk_i) disable iff (!rstn_i)
        (accept && avs_read_i && (idx == MCR_IDX_ALGO_CMD)) |=> (avs_readdata_o == 32'h0000_0000);
    endproperty
    a_algo_rd: assert property (p_algo_rd) // RULE_10
        else $error("command word read not zero");

    property p_speed_rd;
        @(posedge mclk_i) disable iff (!rstn_i)
        (accept && avs_read_i && (idx == MCR_IDX_SPEED_CMD))
            |=> (avs_readdata_o[14:0] == 15'h0000) && (avs_readdata_o[31:15] == speed_r[31:15]);
    endproperty
    a_speed_rd: assert property (p_speed_rd) // RULE_11
        else $error("speed word readback wrong");

    property p_setpt;
        @(posedge mclk_i) disable iff (!rstn_i)
        (wr_done && (idx == MCR_IDX_SPEED_CMD) && (avs_byteenable_i[3:2] == 2'b11))
            |=> (speed_setpoint_o == $past(avs_writedata_i[MCR_SETPT_HI:MCR_SETPT_LO]));
    endproperty
    a_setpt: assert property (p_setpt) // RULE_12
        else $error("setpoint not written");

    property p_src;
        @(posedge mclk_i) disable iff (!rstn_i)
        1'b1 |=> (speed_cmd_o == ($past(speed_source_select_o) ? $past(speed_setpoint_o)
            : $past(speed_pin_cmd_i)));
    endproperty
    a_src: assert property (p_src) // RULE_13
        else $error("speed source mux wrong");

    property p_clr_once;
        @(posedge mclk_i) disable iff (!rstn_i)
        (fault_clear_cmd_o || retry_counter_clear_cmd_o)
            |=> !(fault_clear_cmd_o || retry_counter_clear_cmd_o);
    endproperty
    a_clr_once: assert property (p_clr_once) // RULE_14
        else $error("clear command held longer than one cycle");

    property p_rej_excl;
        @(posedge mclk_i) disable iff (!rstn_i)
        key_reject_o |-> !nvm_store_cmd_o && $past(algo_wr) && $past(wdata_m[MCR_STORE_BIT]);
    endproperty
    a_rej_excl: assert property (p_rej_excl) // RULE_15
        else $error("key reject without a store write");

    // speed word must only move on an accepted write to its own index
    property p_speed_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        !(wr_done && (idx == MCR_IDX_SPEED_CMD))
            |=> $stable(speed_setpoint_o) && $stable(speed_source_select_o);
    endproperty
    a_speed_hold: assert property (p_speed_hold) // RULE_11
        else $error("speed word changed without a write");

endmodule // mcr_regs

// File: rtl/mcr_pkg.sv
package mcr_pkg;

    // word indices; byte address is four times the index
    localparam logic [9:0] MCR_IDX_ALGO_CMD = 10'h0e6;
    localparam logic [9:0] MCR_IDX_SPEED_CMD = 10'h0e8;
    localparam logic [9:0] MCR_IDX_STATUS = 10'h0ec;

    // command word fields
    localparam int MCR_STORE_BIT = 31;
    localparam int MCR_LOAD_BIT = 30;
    localparam int MCR_FCLR_BIT = 29;
    localparam int MCR_RCLR_BIT = 28;
    localparam int MCR_KEY_HI = 27;
    localparam int MCR_KEY_LO = 20;
    localparam int MCR_KICK_BIT = 0;

    // speed command word fields
    localparam int MCR_SETPT_HI = 30;
    localparam int MCR_SETPT_LO = 16;
    localparam int MCR_SRC_BIT = 15;
    localparam logic [31:0] MCR_SPEED_WR_MASK = 32'hffff_8000;

    // status word fields: current lsb is 1/256 A, power lsb is 1/64 W
    localparam int MCR_CUR_HI = 31;
    localparam int MCR_CUR_LO = 16;
    localparam int MCR_PWR_HI = 15;
    localparam int MCR_PWR_LO = 0;

    // reset values
    localparam logic [31:0] MCR_ALGO_RST = 32'h0000_0000;
    localparam logic [31:0] MCR_SPEED_RST = 32'h0000_0000;
    localparam logic [31:0] MCR_RDATA_RST = 32'h0000_0000;

    // expected store key, arbitrary default
    localparam logic [7:0] MCR_NVM_KEY_DEF = 8'h5a;

    typedef struct packed {
        logic store;
        logic load;
        logic fault_clear;
        logic retry_clear;
        logic kick;
    } mcr_cmd_t;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] power;
    } mcr_meas_t;

    typedef enum logic [1:0] {
        MCR_BUS_IDLE = 2'b01,
        MCR_BUS_ACK = 2'b10
    } mcr_bus_t;

    function automatic logic [31:0] mcr_be_mask(input logic [3:0] be);
        mcr_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

endpackage

// File: rtl/mcr_cmd_decode.sv
`timescale 1ns/1ns
module mcr_cmd_decode
    import mcr_pkg::*;
#(
    parameter logic [7:0] NVM_KEY = MCR_NVM_KEY_DEF
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // accepted command word write
    input wire logic wr_i,
    input wire logic [31:0] data_i,
    // one-cycle command pulses
    output mcr_cmd_t cmd_o,
    output logic key_reject_o
);

    mcr_cmd_t cmd_r, cmd_nxt;
    logic rej_r, rej_nxt;
    logic key_ok;

    always_comb begin
        key_ok = (data_i[MCR_KEY_HI:MCR_KEY_LO] == NVM_KEY);
        cmd_nxt = '0;
        rej_nxt = 1'b0;
        // pulses only; nothing of the word is kept
        if (wr_i) begin // RULE_14
            cmd_nxt.store = data_i[MCR_STORE_BIT] && key_ok; // RULE_03 RULE_07 RULE_15
            rej_nxt = data_i[MCR_STORE_BIT] && !key_ok; // RULE_15
            cmd_nxt.load = data_i[MCR_LOAD_BIT]; // RULE_04
            cmd_nxt.fault_clear = data_i[MCR_FCLR_BIT]; // RULE_05
            cmd_nxt.retry_clear = data_i[MCR_RCLR_BIT]; // RULE_06
            cmd_nxt.kick = data_i[MCR_KICK_BIT]; // RULE_08
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_r <= '0;
            rej_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            rej_r <= rej_nxt;
        end
    end

    assign cmd_o = cmd_r;
    assign key_reject_o = rej_r;

endmodule // mcr_cmd_decode

// File: sim/mcr_core_model.sv
`timescale 1ns/1ns
module mcr_core_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // how slowly the core notices a kick
    input wire logic [7:0] ack_dly_i,
    // kick in, acknowledge out
    input wire logic kick_i,
    output logic wd_seen_o
);
    logic [7:0] cnt_r;

    // one-cycle ack; a late ack keeps the kick standing longer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 8'h00;
            wd_seen_o <= 1'b0;
        end else begin
            wd_seen_o <= kick_i && !wd_seen_o && (cnt_r >= ack_dly_i);
            cnt_r <= (kick_i && !wd_seen_o) ? cnt_r + 8'h01 : 8'h00;
        end
    end
endmodule // mcr_core_model

// File: sim/mcr_regs_tb_top.sv
`timescale 1ns/1ns
module mcr_regs_tb_top;
    import mcr_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [11:0] addr = 12'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'hf;
    logic [15:0] cur = 16'h0000;
    logic [15:0] pwr = 16'h0000;
    logic [14:0] pin = 15'h0000;
    logic [7:0] ack_dly = 8'h00;
    logic [31:0] rdata;
    logic waitreq, wd_seen, st, ld, fc, rc, rej, kick, sel;
    logic [14:0] setpt, spd;
    logic [4:0] pulses;
    logic [31:0] got, gp, d;
    logic [31:0] rd_q[$];
    logic [4:0] pl_q[$];
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] cd[8] = '{32'h85a0_0000, 32'h8a50_0000, 32'h4000_0000, 32'h2000_0000,
                           32'h1000_0000, 32'hf5a0_0000, 32'h85a0_0000, 32'h85a0_0000};
    logic [3:0] ce[8] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3, 4'h8};
    // masked key bytes read as zero, so a partial store is refused
    logic [4:0] cx[8] = '{5'h10, 5'h01, 5'h08, 5'h04, 5'h02, 5'h1e, 5'h00, 5'h01};
    logic [7:0] dl[2] = '{8'h00, 8'h14};

    always #25 mclk_i = ~mclk_i;
    assign pulses = {st, ld, fc, rc, rej};

    mcr_regs mcr_regs_inst (
        .mclk_i(mclk_i), .rstn_i(rstn_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .bus_current_reading_i(cur), .input_power_reading_i(pwr),
        .speed_pin_cmd_i(pin), .wd_seen_i(wd_seen),
        .nvm_store_cmd_o(st), .nvm_load_cmd_o(ld), .fault_clear_cmd_o(fc),
        .retry_counter_clear_cmd_o(rc), .key_reject_o(rej),
        .host_watchdog_kick_o(kick), .speed_setpoint_o(setpt),
        .speed_source_select_o(sel), .speed_cmd_o(spd)
    );

    mcr_core_model mcr_core_model_inst (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .ack_dly_i(ack_dly),
        .kick_i(kick), .wd_seen_o(wd_seen)
    );

    task automatic print_verdict;
        if (fail_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (exp !== seen) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // holds the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dd,
                       input logic [3:0] e);
        int n;
        n = 0;
        @(posedge mclk_i);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= dd;
        be <= e;
        do begin
            @(posedge mclk_i);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) fail_count++;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 32'h0000_0000, 4'hf);
    endtask

    // read data checked at the edge where waitrequest is sampled low
    always @(posedge mclk_i) begin
        if (rd && waitreq === 1'b0) begin
            got = rd_q.size() ? rd_q.pop_front() : 32'hxxxx_xxxx;
            chk("readdata", got, rdata);
        end
    end

    // any pulse must match the oldest expected pulse set
    always @(negedge mclk_i) begin
        if (rstn_i && pulses !== 5'h00) begin
            gp = pl_q.size() ? {27'h0, pl_q.pop_front()} : 32'hxxxx_xxxx;
            chk("pulses", gp, {27'h0, pulses});
        end
    end

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(46));
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd_chk(12'h3a0, MCR_SPEED_RST);
        rd_chk(12'h398, MCR_ALGO_RST);
        rd_chk(12'h3a4, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            if (cx[i] != 5'h00) pl_q.push_back(cx[i]);
            bus(1'b1, 12'h398, cd[i], ce[i]);
        end
        d = {4'h8, 8'($urandom_range(8'h5b, 8'hff)), 20'h00000};
        pl_q.push_back(5'h01);
        bus(1'b1, 12'h398, d, 4'hf);
        rd_chk(12'h398, 32'h0000_0000);
        foreach (dl[i]) begin
            @(posedge mclk_i);
            ack_dly <= dl[i];
            bus(1'b1, 12'h398, 32'h0000_0001, 4'hf);
            repeat (2) @(negedge mclk_i);
            chk("kick_set", 32'h1, {31'h0, kick});
            repeat (int'(dl[i]) + 6) @(negedge mclk_i);
            chk("kick_clear", 32'h0, {31'h0, kick});
        end
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            d[15] = i[0];
            if (i == 3) d[30:16] = 15'h7fff;
            @(posedge mclk_i);
            pin <= 15'($urandom);
            cur <= 16'($urandom);
            pwr <= 16'($urandom);
            bus(1'b1, 12'h3a0, d, 4'hf);
            repeat (2) @(negedge mclk_i);
            chk("setpoint", {17'h0, d[30:16]}, {17'h0, setpt});
            chk("select", {31'h0, d[15]}, {31'h0, sel});
            chk("speed_cmd", {17'h0, d[15] ? d[30:16] : pin}, {17'h0, spd});
            rd_chk(12'h3a0, d & MCR_SPEED_WR_MASK);
            rd_chk(12'h3b0, {cur, pwr});
        end
        // reset in mid-run must drop the stored speed word
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        chk("reset_speed", 32'h0, {16'h0, sel, setpt});
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd_chk(12'h3a0, MCR_SPEED_RST);
        repeat (5) @(posedge mclk_i);
        chk("pending", 32'h0, 32'(rd_q.size() + pl_q.size()));
        print_verdict();
    end
endmodule // mcr_regs_tb_top
